/* File: core/ccpm_channel.sv */
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
//
// Contract
// - mode 0000 turns channel off and resets it
// - 0100 captures falling edges, 0101 rising edges
// - 0110 every fourth, 0111 every sixteenth rise
// - 0010 toggles channel pin on compare match
// - 1000 sets pin high, sets event flag
// - 1001 drives pin low, sets event flag
// - 1010 sets event flag only, pin untouched
// - 1011 sets flag, resets selected time base
// - fifth channel trigger sets converter on, starts if enabled
// - upper mode bits 11 mean PWM, polarity below
// - duty low bits extend duty register in PWM
// - capture/compare uses A; B, C, D port pins
// - half bridge: 0x single A, 1x A/B dead-band
// - full bridge 00 single, 10 half bridge
// - full bridge 01 forward: D mod, A on
// - full bridge 11 reverse: B mod, C on
// - full bridge polarity: bit1 A/C, bit0 B/D
// - single output steers to enabled outputs
module ccpm_channel #(
  parameter bit FULL_BRIDGE = 1'b1,
  parameter bit FIFTH_CHANNEL = 1'b0,
  parameter int DEAD_CYCLES = ccpm_pkg::DEAD_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // selected time base
  input wire logic [15:0] time_base_count,
  input wire logic compare_match,
  input wire logic [9:0] pwm_count,
  output logic [1:0] timer_select,
  output logic time_base_reset,
  // converter
  input wire logic converter_enable,
  output logic converter_on,
  output logic conversion_start,
  // channel pin input for capture
  input wire logic channel_pin_in,
  // four outputs, oe_n low while driven
  output logic pwm_out_a,
  output logic pwm_out_a_oe_n,
  output logic pwm_out_b,
  output logic pwm_out_b_oe_n,
  output logic pwm_out_c,
  output logic pwm_out_c_oe_n,
  output logic pwm_out_d,
  output logic pwm_out_d_oe_n,
  // event flag
  output logic channel_event_flag
);
  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] output_config_q;
  logic [1:0] duty_low_bits_q;
  logic [3:0] channel_mode_select_q;
  logic [7:0] duty_high_register_q;
  logic [3:0] steer_q; // d, c, b, a enables
  logic [1:0] timer_select_q;
  logic event_q;
  logic conv_on_q;
  logic [15:0] capture_q;
  logic [7:0] rdata_q;

  // decoded writes
  logic wr_ctrl, wr_status;
  assign wr_ctrl = reg_wr && (reg_addr == ccpm_pkg::ADDR_CTRL);
  assign wr_status = reg_wr && (reg_addr == ccpm_pkg::ADDR_STATUS);

  // mode classes
  logic is_pwm, is_capture, is_compare;
  assign is_pwm = channel_mode_select_q[3:2] == ccpm_pkg::MODE_PWM_TOP;
  assign is_capture = channel_mode_select_q[3:2] == 2'h1;
  // reserved codes 0001 and 0011 fall in none of the classes
  assign is_compare = (channel_mode_select_q == ccpm_pkg::MODE_TOGGLE) ||
                      (channel_mode_select_q[3:2] == 2'h2);

  // control register write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      output_config_q <= ccpm_pkg::CTRL_RST[ccpm_pkg::CFG_MSB:ccpm_pkg::CFG_LSB];
      duty_low_bits_q <= ccpm_pkg::CTRL_RST[ccpm_pkg::DLOW_MSB:ccpm_pkg::DLOW_LSB];
      channel_mode_select_q <= ccpm_pkg::CTRL_RST[ccpm_pkg::MODE_MSB:ccpm_pkg::MODE_LSB];
    end else if (wr_ctrl) begin
      output_config_q <= reg_wdata[ccpm_pkg::CFG_MSB:ccpm_pkg::CFG_LSB];
      duty_low_bits_q <= reg_wdata[ccpm_pkg::DLOW_MSB:ccpm_pkg::DLOW_LSB];
      channel_mode_select_q <= reg_wdata[ccpm_pkg::MODE_MSB:ccpm_pkg::MODE_LSB];
    end
  end

  // duty, steering and timer select registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      duty_high_register_q <= ccpm_pkg::DUTY_HI_RST;
      steer_q <= ccpm_pkg::STEER_RST;
      timer_select_q <= ccpm_pkg::TSEL_RST;
    end else if (reg_wr) begin
      if (reg_addr == ccpm_pkg::ADDR_DUTY_HI) begin
        duty_high_register_q <= reg_wdata;
      end
      if (reg_addr == ccpm_pkg::ADDR_STEER) begin
        steer_q <= reg_wdata[3:0];
      end
      if (reg_addr == ccpm_pkg::ADDR_TSEL) begin
        timer_select_q <= reg_wdata[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture input synchroniser and edge detect
  logic pin_s1_q, pin_s2_q, pin_s3_q;

  // two flops before any logic, a third for the edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else begin
      pin_s1_q <= channel_pin_in;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  logic rise, fall;
  assign rise = pin_s2_q && !pin_s3_q;
  assign fall = !pin_s2_q && pin_s3_q;

  // rising-edge prescaler, restarted on every mode write
  logic [3:0] pre_q;
  logic pre_hit;
  always_comb begin
    pre_hit = 1'b0;
    unique case (channel_mode_select_q)
      ccpm_pkg::MODE_CAP_4: pre_hit = rise && (pre_q == ccpm_pkg::PRE_4_LAST);
      ccpm_pkg::MODE_CAP_16: pre_hit = rise && (pre_q == ccpm_pkg::PRE_16_LAST);
      default: pre_hit = 1'b0;
    endcase
  end

  // prescale counter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pre_q <= 4'h0;
    end else if (wr_ctrl || pre_hit) begin
      pre_q <= 4'h0;
    end else if (rise) begin
      pre_q <= pre_q + 4'h1;
    end
  end

  // capture event select
  logic cap_evt;
  always_comb begin
    cap_evt = 1'b0;
    if (channel_mode_select_q == ccpm_pkg::MODE_CAP_FALL) begin
      cap_evt = fall;
    end else if (channel_mode_select_q == ccpm_pkg::MODE_CAP_RISE) begin
      cap_evt = rise;
    end else begin
      cap_evt = pre_hit;
    end
  end

  // capture register holds the time base at the event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      capture_q <= 16'h0000;
    end else if (is_capture && cap_evt) begin
      capture_q <= time_base_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare actions
  logic cmp_evt;
  assign cmp_evt = is_compare && compare_match;

  // compare output latch on the channel pin
  logic cmp_pin_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cmp_pin_q <= 1'b0;
    end else if (wr_ctrl && (reg_wdata[3:0] == ccpm_pkg::MODE_OFF)) begin
      cmp_pin_q <= 1'b0;
    end else if (cmp_evt) begin
      if (channel_mode_select_q == ccpm_pkg::MODE_TOGGLE) begin
        cmp_pin_q <= !cmp_pin_q;
      end else if (channel_mode_select_q == ccpm_pkg::MODE_CMP_SET) begin
        cmp_pin_q <= 1'b1;
      end else if (channel_mode_select_q == ccpm_pkg::MODE_CMP_CLR) begin
        cmp_pin_q <= 1'b0;
      end
      // soft and trigger modes leave the pin alone
    end
  end

  // flag-setting events: captures and compares alike
  logic flag_evt, trig_evt;
  assign flag_evt = (is_capture && cap_evt) || cmp_evt;
  assign trig_evt = cmp_evt && (channel_mode_select_q == ccpm_pkg::MODE_CMP_TRIG);

  // sticky flags, write one to clear; a same-cycle event wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      event_q <= 1'b0;
      conv_on_q <= 1'b0;
    end else begin
      if (flag_evt) begin
        event_q <= 1'b1;
      end else if (wr_status && reg_wdata[ccpm_pkg::ST_EVENT]) begin
        event_q <= 1'b0;
      end
      if (FIFTH_CHANNEL && trig_evt) begin
        conv_on_q <= 1'b1;
      end else if (wr_status && reg_wdata[ccpm_pkg::ST_CONV_ON]) begin
        conv_on_q <= 1'b0;
      end
    end
  end

  // one-cycle pulses to the time base and converter
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      time_base_reset <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      time_base_reset <= trig_evt;
      conversion_start <= FIFTH_CHANNEL && trig_evt && converter_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pwm modulation and dead band
  logic [9:0] duty;
  logic modulated;
  // low bits only matter in pwm; outside it the comparison is unused
  assign duty = {duty_high_register_q, duty_low_bits_q};
  assign modulated = is_pwm && (pwm_count < duty);

  logic half_mode;
  assign half_mode = is_pwm && (FULL_BRIDGE ? (output_config_q == ccpm_pkg::CFG_HALF)
                                            : output_config_q[1]);
  logic db_a, db_b;

  ccpm_dead_band #(.DELAY(DEAD_CYCLES)) u_db_a (
    .core_clk(core_clk),
    .rst(rst),
    .enable(half_mode),
    .drive_in(modulated),
    .drive_out(db_a)
  );

  ccpm_dead_band #(.DELAY(DEAD_CYCLES)) u_db_b (
    .core_clk(core_clk),
    .rst(rst),
    .enable(half_mode),
    .drive_in(!modulated),
    .drive_out(db_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output mapping: active level first, polarity applied last
  logic [3:0] act_d; // d, c, b, a active-true levels
  logic [3:0] drv_d; // d, c, b, a driven by this block
  logic pol_ac, pol_bd;
  assign pol_ac = channel_mode_select_q[1];
  assign pol_bd = channel_mode_select_q[0];

  always_comb begin
    act_d = 4'h0;
    drv_d = 4'h0;
    if (is_capture || is_compare) begin
      // capture input or compare output on a only
      act_d = {3'h0, cmp_pin_q};
      drv_d = {3'h0, is_compare};
    end else if (is_pwm && half_mode) begin
      act_d = {2'h0, db_b, db_a};
      drv_d = 4'h3;
    end else if (is_pwm && FULL_BRIDGE && (output_config_q == ccpm_pkg::CFG_FWD)) begin
      act_d = {modulated, 2'h0, 1'b1};
      drv_d = 4'hf;
    end else if (is_pwm && FULL_BRIDGE && (output_config_q == ccpm_pkg::CFG_REV)) begin
      act_d = {1'b0, 1'b1, modulated, 1'b0};
      drv_d = 4'hf;
    end else if (is_pwm && FULL_BRIDGE) begin
      // single output, steered to any enabled pins
      act_d = {4{modulated}};
      drv_d = steer_q;
    end else if (is_pwm) begin
      act_d = {3'h0, modulated};
      drv_d = 4'h1;
    end
    // off and reserved modes drive nothing
  end

  // registered pins; compare output keeps its true level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwm_out_a <= 1'b0;
      pwm_out_b <= 1'b0;
      pwm_out_c <= 1'b0;
      pwm_out_d <= 1'b0;
      pwm_out_a_oe_n <= 1'b1;
      pwm_out_b_oe_n <= 1'b1;
      pwm_out_c_oe_n <= 1'b1;
      pwm_out_d_oe_n <= 1'b1;
    end else begin
      pwm_out_a <= act_d[0] ^ (is_pwm && pol_ac);
      pwm_out_b <= act_d[1] ^ (is_pwm && pol_bd);
      pwm_out_c <= act_d[2] ^ (is_pwm && pol_ac);
      pwm_out_d <= act_d[3] ^ (is_pwm && pol_bd);
      pwm_out_a_oe_n <= !drv_d[0];
      pwm_out_b_oe_n <= !drv_d[1];
      pwm_out_c_oe_n <= !drv_d[2];
      pwm_out_d_oe_n <= !drv_d[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ccpm_pkg::ADDR_CTRL: rdata_q <= {output_config_q, duty_low_bits_q,
                                         channel_mode_select_q};
        ccpm_pkg::ADDR_DUTY_HI: rdata_q <= duty_high_register_q;
        ccpm_pkg::ADDR_STEER: rdata_q <= {4'h0, steer_q};
        ccpm_pkg::ADDR_TSEL: rdata_q <= {6'h00, timer_select_q};
        ccpm_pkg::ADDR_STATUS: rdata_q <= {6'h00, conv_on_q, event_q};
        ccpm_pkg::ADDR_CAP_LO: rdata_q <= capture_q[7:0];
        ccpm_pkg::ADDR_CAP_HI: rdata_q <= capture_q[15:8];
        default: rdata_q <= 8'h00; // unmapped reads zero
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // outputs straight from flops
  assign reg_rdata = rdata_q;
  assign timer_select = timer_select_q;
  assign converter_on = conv_on_q;
  assign channel_event_flag = event_q;
endmodule
`default_nettype wire

/* File: core/ccpm_pkg.sv */
package ccpm_pkg;
  // register map, word index on the plain port
  localparam logic [2:0] ADDR_CTRL = 3'h0;
  localparam logic [2:0] ADDR_DUTY_HI = 3'h1;
  localparam logic [2:0] ADDR_STEER = 3'h2;
  localparam logic [2:0] ADDR_TSEL = 3'h3;
  localparam logic [2:0] ADDR_STATUS = 3'h4;
  localparam logic [2:0] ADDR_CAP_LO = 3'h5;
  localparam logic [2:0] ADDR_CAP_HI = 3'h6;

  // control register fields
  localparam int CFG_MSB = 7;
  localparam int CFG_LSB = 6;
  localparam int DLOW_MSB = 5;
  localparam int DLOW_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 0;

  // status register fields
  localparam int ST_EVENT = 0;
  localparam int ST_CONV_ON = 1;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DUTY_HI_RST = 8'h00;
  localparam logic [3:0] STEER_RST = 4'h1;
  localparam logic [1:0] TSEL_RST = 2'h0;

  // mode codes
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4 = 4'h6;
  localparam logic [3:0] MODE_CAP_16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'ha;
  localparam logic [3:0] MODE_CMP_TRIG = 4'hb;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // output configuration codes
  localparam logic [1:0] CFG_SINGLE = 2'h0;
  localparam logic [1:0] CFG_FWD = 2'h1;
  localparam logic [1:0] CFG_HALF = 2'h2;
  localparam logic [1:0] CFG_REV = 2'h3;

  // capture prescale terminal counts
  localparam logic [3:0] PRE_4_LAST = 4'h3;
  localparam logic [3:0] PRE_16_LAST = 4'hf;

  // dead band time and its cycle count at 250 MHz
  localparam int CLK_MHZ = 250;
  localparam int DEAD_NS = 20;
  localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
endpackage

/* File: core/ccpm_dead_band.sv */
`timescale 1ns/10ps
`default_nettype none
// delays the rising edge of a drive signal, falls at once
module ccpm_dead_band #(
  parameter int DELAY = 5
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // drive in and delayed drive out
  input wire logic enable,
  input wire logic drive_in,
  output logic drive_out
);
  // counts cycles the input has been high
  logic [7:0] cnt_q;

  // hold-off counter, cleared whenever the input drops
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 8'h00;
    end else if (!enable || !drive_in) begin
      cnt_q <= 8'h00;
    end else if (cnt_q < 8'(DELAY)) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // both switches of a leg never conduct together: falls first, rises late
  assign drive_out = enable && drive_in && (cnt_q >= 8'(DELAY));
endmodule
`default_nettype wire

/* File: dv/ccpm_channel_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// watches channel ports; shadows the control word from register writes
module ccpm_channel_assertions #(
  parameter bit FIFTH_CHANNEL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // register writes
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // time base and converter
  input wire logic compare_match,
  input wire logic time_base_reset,
  input wire logic converter_enable,
  input wire logic converter_on,
  input wire logic conversion_start,
  // outputs and flag
  input wire logic pwm_out_a,
  input wire logic pwm_out_a_oe_n,
  input wire logic pwm_out_b,
  input wire logic pwm_out_b_oe_n,
  input wire logic pwm_out_c,
  input wire logic pwm_out_c_oe_n,
  input wire logic pwm_out_d,
  input wire logic pwm_out_d_oe_n,
  input wire logic channel_event_flag
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_q; // shadow of control word
  logic [3:0] quiet_q; // cycles since last control write
  logic [3:0] mode;
  logic [1:0] cfg;
  logic settled; // past dead band and output pipeline
  logic [3:0] oe_n;
  assign mode = ctrl_q[3:0];
  assign cfg = ctrl_q[7:6];
  assign settled = quiet_q > 4'h8;
  assign oe_n = {pwm_out_d_oe_n, pwm_out_c_oe_n, pwm_out_b_oe_n, pwm_out_a_oe_n};
  // shadow follows writes; counter saturates so it never wraps to zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= ccpm_pkg::CTRL_RST;
      quiet_q <= 4'h0;
    end else if (reg_wr && reg_addr == ccpm_pkg::ADDR_CTRL) begin
      ctrl_q <= reg_wdata;
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  a_set_match: assert property (compare_match && mode == 4'h8 |=> ##1
    pwm_out_a && channel_event_flag) else $error("set mode missed");
  a_clr_match: assert property (compare_match && mode == 4'h9 |=> ##1
    !pwm_out_a && channel_event_flag) else $error("clear mode missed");
  a_toggle_match: assert property (compare_match && mode == 4'h2 && quiet_q > 4'h2
    |=> ##1 pwm_out_a != $past(pwm_out_a, 2)) else $error("toggle missed");
  a_soft_keeps: assert property (compare_match && mode == 4'ha |=> ##1
    $stable(pwm_out_a) && channel_event_flag) else $error("soft mode moved pin");
  a_trig_reset: assert property (compare_match && mode == 4'hb |=>
    time_base_reset ##1 !time_base_reset) else $error("trigger reset missed");
  a_reset_cause: assert property (time_base_reset |-> $past(compare_match))
    else $error("time base reset without match");
  a_conv_start: assert property (FIFTH_CHANNEL && compare_match && mode == 4'hb
    && converter_enable |=> conversion_start ##1 converter_on) else $error("no conversion");
  a_off_quiet: assert property (settled && (mode == 4'h0 || mode == 4'h1 || mode == 4'h3)
    |-> oe_n == 4'hf && !pwm_out_a) else $error("off mode drives outputs");
  a_port_pins: assert property (settled && mode[3:2] != 2'h3 |-> oe_n[3:1] == 3'h7
    && (mode[3:2] != 2'h1 || oe_n[0])) else $error("port pins driven");
  a_fwd_static: assert property (settled && mode[3:2] == 2'h3 && cfg == 2'h1 |->
    pwm_out_a == !mode[1] && pwm_out_b == mode[0] && pwm_out_c == mode[1] && oe_n == 4'h0)
    else $error("forward levels wrong");
  a_rev_static: assert property (settled && mode[3:2] == 2'h3 && cfg == 2'h3 |->
    pwm_out_c == !mode[1] && pwm_out_a == mode[1] && pwm_out_d == mode[0] && oe_n == 4'h0)
    else $error("reverse levels wrong");
  a_half_ports: assert property (settled && mode[3:2] == 2'h3 && cfg == 2'h2 |->
    oe_n[3:2] == 2'h3) else $error("half bridge drives c or d");
  c_trigger: cover property (compare_match && mode == 4'hb);
  c_reverse: cover property (settled && mode[3:2] == 2'h3 && cfg == 2'h3);
  c_convert: cover property (conversion_start);
endmodule
bind ccpm_channel ccpm_channel_assertions #(.FIFTH_CHANNEL(FIFTH_CHANNEL))
  ccpm_channel_assertions_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
  .compare_match, .time_base_reset, .converter_enable, .converter_on, .conversion_start,
  .pwm_out_a, .pwm_out_a_oe_n, .pwm_out_b, .pwm_out_b_oe_n, .pwm_out_c, .pwm_out_c_oe_n,
  .pwm_out_d, .pwm_out_d_oe_n, .channel_event_flag);
`default_nettype wire

/* File: dv/ccpm_far_side.sv */
`timescale 1ns/10ps
`default_nettype none
// time base beside the channel; frozen on demand so captures are predictable
module ccpm_far_side (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // run control and reset request
  input wire logic run,
  input wire logic time_base_reset,
  // counts seen by the channel
  output logic [15:0] time_base_count,
  output logic [9:0] pwm_count
);
  // counter restarts on the trigger request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) time_base_count <= 16'h0000;
    else if (time_base_reset) time_base_count <= 16'h0000;
    else if (run) time_base_count <= time_base_count + 16'h0001;
  end
  // pwm count shares the low bits
  assign pwm_count = time_base_count[9:0];
endmodule
`default_nettype wire

/* File: dv/ccpm_channel_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module ccpm_channel_tb;
  logic core_clk, rst, reg_wr, reg_rd, compare_match, time_base_reset, run, m;
  logic converter_enable, converter_on, conversion_start, channel_pin_in, channel_event_flag;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [15:0] time_base_count;
  logic [9:0] pwm_count, prev;
  logic [1:0] timer_select, pol;
  logic [3:0] out, oe_n, r;
  logic [3:0] cmp_mode [7] = '{4'h8, 4'h9, 4'h2, 4'h2, 4'ha, 4'hb, 4'hb};
  logic [6:0] cmp_a = 7'h05; // expected pin after each compare step
  logic [15:0] role [4] = '{16'h1001, 16'h1332, 16'h0044, 16'h3213}; // 0 port 1 mod 2 on 3 off
  int cap_n [4] = '{1, 1, 4, 16};
  int n_mismatch, cmp_count, n_conv;
  // conversion pulses, counted mid-cycle while they stand
  always @(negedge core_clk) if (conversion_start) n_conv++;
  ////////////////////////////////////////////////////////////////
  ccpm_channel #(.FIFTH_CHANNEL(1'b1)) ccpm_channel_inst (.core_clk, .rst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .time_base_count, .compare_match, .pwm_count,
    .timer_select, .time_base_reset, .converter_enable, .converter_on, .conversion_start,
    .channel_pin_in, .pwm_out_a(out[0]), .pwm_out_a_oe_n(oe_n[0]), .pwm_out_b(out[1]),
    .pwm_out_b_oe_n(oe_n[1]), .pwm_out_c(out[2]), .pwm_out_c_oe_n(oe_n[2]),
    .pwm_out_d(out[3]), .pwm_out_d_oe_n(oe_n[3]), .channel_event_flag);
  ccpm_far_side ccpm_far_side_inst (.core_clk, .rst, .run, .time_base_reset,
    .time_base_count, .pwm_count);
  // clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, exp);
  endtask
  task automatic pulse();
    repeat (6) @(posedge core_clk);
    compare_match <= 1'b1;
    @(posedge core_clk);
    compare_match <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  // n active edges on the capture pin, spaced past the synchroniser
  task automatic edges(input int n, input logic idle);
    repeat (n) begin
      @(posedge core_clk);
      channel_pin_in <= ~idle;
      repeat (4) @(posedge core_clk);
      channel_pin_in <= idle;
      repeat (4) @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic conclude();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog, well past the expected 9k cycles
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    {rst, reg_wr, reg_rd, compare_match, channel_pin_in, run} = 6'h20;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    converter_enable = 1'b1;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    rchk(ccpm_pkg::ADDR_CTRL, ccpm_pkg::CTRL_RST);
    rchk(ccpm_pkg::ADDR_STEER, {4'h0, ccpm_pkg::STEER_RST});
    wr(3'h7, 8'hff);
    rchk(3'h7, 8'h00);
    wr(ccpm_pkg::ADDR_TSEL, 8'h02);
    rchk(ccpm_pkg::ADDR_TSEL, 8'h02);
    chk({6'h0, timer_select}, 8'h02);
    run <= 1'b1;
    // compare actions, trigger last so the converter bit stays clear before it
    // second trigger runs with the converter disabled: bit set, no start pulse
    for (int i = 0; i < 7; i++) begin
      converter_enable <= (i != 6);
      wr(ccpm_pkg::ADDR_CTRL, {4'h0, cmp_mode[i]});
      pulse();
      chk({6'h0, oe_n[0], out[0]}, {7'h0, cmp_a[i]});
      chk({6'h0, converter_on, channel_event_flag}, (i >= 5) ? 8'h03 : 8'h01);
      if (i >= 5) chk({7'h0, time_base_count < 16'h0010}, 8'h01);
      rchk(ccpm_pkg::ADDR_STATUS, (i >= 5) ? 8'h03 : 8'h01);
      wr(ccpm_pkg::ADDR_STATUS, 8'h03);
    end
    chk(8'(n_conv), 8'h01);
    // capture modes, time base frozen so the stored value is known
    run <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      channel_pin_in <= (i == 0);
      repeat (8) @(posedge core_clk);
      wr(ccpm_pkg::ADDR_CTRL, 8'h04 + 8'(i));
      wr(ccpm_pkg::ADDR_STATUS, 8'h03);
      edges(cap_n[i] - 1, i == 0);
      rchk(ccpm_pkg::ADDR_STATUS, 8'h00);
      edges(1, i == 0);
      rchk(ccpm_pkg::ADDR_STATUS, 8'h01);
      rchk(ccpm_pkg::ADDR_CAP_LO, time_base_count[7:0]);
      rchk(ccpm_pkg::ADDR_CAP_HI, time_base_count[15:8]);
    end
    // pwm configurations and polarities, duty 10'h102
    run <= 1'b1;
    wr(ccpm_pkg::ADDR_DUTY_HI, 8'h40);
    wr(ccpm_pkg::ADDR_STEER, 8'h09);
    for (int i = 0; i < 8; i++) begin
      pol = 2'((i + i / 4) % 4);
      wr(ccpm_pkg::ADDR_CTRL, {2'(i % 4), 2'h2, 2'h3, pol});
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      prev = pwm_count;
      repeat (1030) begin
        @(negedge core_clk);
        m = prev < 10'h102;
        for (int j = 0; j < 4; j++) begin
          r = role[i % 4][4 * j +: 4];
          rv = {6'h0, r == 4'h0, (r == 4'h0) ? 1'b0 : out[j]};
          if (r == 4'h0) chk(rv, {6'h0, oe_n[j], 1'b0});
          else if (r != 4'h4) chk(rv, {7'h0, ((r == 4'h1) ? m : (r == 4'h2)) ^
            ((j % 2 == 1) ? pol[0] : pol[1])});
        end
        // dead band: both legs of the half bridge never active together
        if (i % 4 == 2) chk({7'h0, (out[0] ^ pol[1]) && (out[1] ^ pol[0])}, 8'h00);
        prev = pwm_count;
      end
    end
    // off and reserved codes drive nothing and raise no flag
    wr(ccpm_pkg::ADDR_STATUS, 8'h03);
    for (int i = 0; i < 4; i += 1 + (i == 1)) begin
      wr(ccpm_pkg::ADDR_CTRL, 8'(i));
      pulse();
      chk({out, oe_n}, 8'h0f);
      rchk(ccpm_pkg::ADDR_STATUS, 8'h00);
    end
    conclude();
  end
endmodule
`default_nettype wire
